// file: common/fws_pkg.sv
// constants and types for the flash status-polling controller
package fws_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    // apb register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    // ctrl fields
    localparam int CTRL_START = 0;
    localparam int CTRL_OP_LO = 1;
    // status fields
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_TOG1 = 3;
    localparam int ST_TOG2 = 4;
    localparam int ST_ERASING = 5;
    localparam int ST_SUSPENDED = 6;
    localparam int ST_TIMER = 7;
    localparam int ST_RDY_PIN = 8;
    // data bus status bit positions
    localparam int BIT_POLL = 7;
    localparam int BIT_TOG1 = 6;
    localparam int BIT_LIMIT = 5;
    localparam int BIT_TIMER = 3;
    localparam int BIT_TOG2 = 2;
    // operations
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_SECT_ERASE = 3'h2;
    localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
    localparam logic [2:0] OP_STATUS = 3'h4;
    localparam logic [2:0] OP_RESET = 3'h5;
    // command cycle addresses and data
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 21'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 21'h0002AA;
    localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00AA;
    localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_PROG = 16'h00A0;
    localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
    localparam logic [DATA_W-1:0] CMD_SECT = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_CHIP = 16'h0010;
    localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
    localparam logic [2:0] LAST_PROG = 3'h3;
    localparam logic [2:0] LAST_ERASE = 3'h5;
    // timing
    localparam int CLK_NS = 100;
    localparam int T_ACC_NS = 70;
    localparam int T_WP_NS = 35;
    localparam logic [1:0] ACC_CYC = 2'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] WP_CYC = 2'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    // controller states
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_WR_LO = 6'h02,
        S_WR_HI = 6'h04,
        S_RD_LO = 6'h08,
        S_RD_HI = 6'h10,
        S_FINAL = 6'h20
    } fws_state_e;
endpackage

// file: logic/fws_ctrl.sv
// host-side flash program/erase controller with status polling over apb
//Contract
// - host polls the programmed address itself
// - host polls an address inside erased sector
// - host rereads all bits after poll flips; the code rereads once toggle bit six stops toggling
// - host combines both toggle bits for state
`timescale 1ns/1ns
module fws_ctrl
    import fws_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash pins
    output logic [ADDR_W-1:0] flash_addr,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    input wire logic ready_busy_n
);
    fws_state_e state_q, state_d;
    logic [2:0] op_q, op_d, step_q, step_d;
    logic [1:0] cnt_q, cnt_d, nrd_q, nrd_d;
    logic [ADDR_W-1:0] addr_q, addr_d, fa_q, fa_d;
    logic [DATA_W-1:0] wdata_q, wdata_d, dqo_q, dqo_d;
    logic [DATA_W-1:0] cur_q, cur_d, prev_q, prev_d, rdata_q, rdata_d;
    logic busy_q, busy_d, done_q, done_d, fail_q, fail_d;
    logic tog1_q, tog1_d, tog2_q, tog2_d, timer_q, timer_d;
    logic limit_q, limit_d, failrst_q, failrst_d;
    logic oe_q, oe_d, ce_q, ce_d, we_q, we_d, dqoe_q, dqoe_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [2:0] last_step;
    logic [ADDR_W-1:0] cyc_addr;
    logic [DATA_W-1:0] cyc_data;
    logic acc, wr_ok, mapped, start, t1, t2, poll_ok;

    // command cycle table
    always_comb begin
        cyc_addr = UNLOCK_A1;
        cyc_data = UNLOCK_D1;
        last_step = 3'h0;
        case (op_q)
            OP_PROGRAM: begin
                last_step = LAST_PROG;
            end
            OP_SECT_ERASE, OP_CHIP_ERASE: begin
                last_step = LAST_ERASE;
            end
            default: begin
                last_step = 3'h0;
            end
        endcase
        case (step_q)
            3'h1, 3'h4: begin
                cyc_addr = UNLOCK_A2;
                cyc_data = UNLOCK_D2;
            end
            3'h2: begin
                cyc_data = (op_q == OP_PROGRAM) ? CMD_PROG : CMD_ERASE_SETUP;
            end
            3'h3: begin
                if (op_q == OP_PROGRAM) begin
                    cyc_addr = addr_q;
                    cyc_data = wdata_q;
                end
            end
            3'h5: begin
                cyc_addr = (op_q == OP_SECT_ERASE) ? addr_q : UNLOCK_A1;
                cyc_data = (op_q == OP_SECT_ERASE) ? CMD_SECT : CMD_CHIP;
            end
            default: begin
                cyc_data = UNLOCK_D1;
            end
        endcase
        if (op_q == OP_RESET) begin
            cyc_data = CMD_RESET;
        end
    end

    // toggle detection between the last two reads
    assign t1 = cur_q[BIT_TOG1] ^ prev_q[BIT_TOG1];
    assign t2 = cur_q[BIT_TOG2] ^ prev_q[BIT_TOG2];
    // program expects true bit seven, erase expects one
    assign poll_ok = (op_q == OP_PROGRAM) ?
        (cur_q[BIT_POLL] == wdata_q[BIT_POLL]) : cur_q[BIT_POLL];

    // apb decode
    assign acc = psel && penable;
    assign wr_ok = acc && pready_q && pwrite;
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_ADDR) ||
        (paddr == REG_WDATA) || (paddr == REG_STATUS) ||
        (paddr == REG_RDATA);
    assign start = wr_ok && (paddr == REG_CTRL) && pwdata[CTRL_START] &&
        !busy_q;

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        step_d = step_q;
        cnt_d = cnt_q;
        nrd_d = nrd_q;
        addr_d = addr_q;
        fa_d = fa_q;
        wdata_d = wdata_q;
        dqo_d = dqo_q;
        cur_d = cur_q;
        prev_d = prev_q;
        rdata_d = rdata_q;
        busy_d = busy_q;
        done_d = done_q;
        fail_d = fail_q;
        tog1_d = tog1_q;
        tog2_d = tog2_q;
        timer_d = timer_q;
        limit_d = limit_q;
        failrst_d = failrst_q;
        oe_d = oe_q;
        ce_d = ce_q;
        we_d = we_q;
        dqoe_d = dqoe_q;
        pready_d = acc && !pready_q;
        pslverr_d = acc && !pready_q && !mapped;
        prdata_d = prdata_q;
        if (acc && !pready_q && !pwrite) begin
            case (paddr)
                REG_CTRL: prdata_d = {29'h0, op_q};
                REG_ADDR: prdata_d = {11'h0, addr_q};
                REG_WDATA: prdata_d = {16'h0, wdata_q};
                REG_STATUS: prdata_d = {23'h0, ready_busy_n, timer_q,
                    tog2_q && !tog1_q, tog2_q && tog1_q, tog2_q, tog1_q,
                    fail_q, done_q, busy_q};
                REG_RDATA: prdata_d = {16'h0, rdata_q};
                default: prdata_d = 32'h0;
            endcase
        end
        if (wr_ok && paddr == REG_ADDR && !busy_q) begin
            addr_d = pwdata[ADDR_W-1:0];
        end
        if (wr_ok && paddr == REG_WDATA && !busy_q) begin
            wdata_d = pwdata[DATA_W-1:0];
        end
        case (state_q)
            S_IDLE: begin
                if (start) begin
                    op_d = pwdata[CTRL_OP_LO +: 3];
                    step_d = 3'h0;
                    nrd_d = 2'h0;
                    busy_d = 1'b1;
                    done_d = 1'b0;
                    fail_d = 1'b0;
                    limit_d = 1'b0;
                    failrst_d = 1'b0;
                    cnt_d = 2'h0;
                    if (pwdata[CTRL_OP_LO +: 3] == OP_READ ||
                        pwdata[CTRL_OP_LO +: 3] == OP_STATUS) begin
                        fa_d = addr_q;
                        ce_d = 1'b1;
                        oe_d = 1'b1;
                        state_d = S_RD_LO;
                    end else begin
                        state_d = S_WR_LO;
                    end
                end
            end
            S_WR_LO: begin
                fa_d = cyc_addr;
                dqo_d = cyc_data;
                dqoe_d = 1'b1;
                ce_d = 1'b1;
                // strobe only once address, data and select have settled
                we_d = ce_q && dqoe_q;
                cnt_d = cnt_q + 2'h1;
                if (cnt_q + 2'h1 >= WP_CYC && we_q) begin
                    we_d = 1'b0;
                    ce_d = 1'b0;
                    dqoe_d = 1'b0;
                    cnt_d = 2'h0;
                    state_d = S_WR_HI;
                end
            end
            S_WR_HI: begin
                ce_d = 1'b0;
                dqoe_d = 1'b0;
                if (step_q == last_step) begin
                    if (op_q == OP_RESET) begin
                        busy_d = 1'b0;
                        done_d = 1'b1;
                        fail_d = failrst_q;
                        state_d = S_IDLE;
                    end else begin
                        // first status read only after the last pulse
                        fa_d = addr_q;
                        ce_d = 1'b1;
                        oe_d = 1'b1;
                        state_d = S_RD_LO;
                    end
                end else begin
                    step_d = step_q + 3'h1;
                    state_d = S_WR_LO;
                end
            end
            S_RD_LO: begin
                cnt_d = cnt_q + 2'h1;
                if (cnt_q + 2'h1 >= ACC_CYC) begin
                    cnt_d = 2'h0;
                    prev_d = cur_q;
                    cur_d = dq_in;
                    oe_d = 1'b0;
                    ce_d = 1'b0;
                    if (nrd_q != 2'h2) begin
                        nrd_d = nrd_q + 2'h1;
                    end
                    state_d = S_RD_HI;
                end
            end
            S_RD_HI: begin
                if (op_q == OP_READ) begin
                    rdata_d = cur_q;
                    busy_d = 1'b0;
                    done_d = 1'b1;
                    state_d = S_IDLE;
                end else if (nrd_q < 2'h2) begin
                    ce_d = 1'b1;
                    oe_d = 1'b1;
                    state_d = S_RD_LO;
                end else begin
                    tog1_d = t1;
                    tog2_d = t2;
                    timer_d = cur_q[BIT_TIMER];
                    if (op_q == OP_STATUS) begin
                        rdata_d = cur_q;
                        busy_d = 1'b0;
                        done_d = 1'b1;
                        state_d = S_IDLE;
                    end else if (!t1) begin
                        // one more read for settled data
                        ce_d = 1'b1;
                        oe_d = 1'b1;
                        state_d = S_FINAL;
                    end else if (limit_q) begin
                        // still toggling after limit seen: abort
                        failrst_d = 1'b1;
                        op_d = OP_RESET;
                        step_d = 3'h0;
                        state_d = S_WR_LO;
                    end else begin
                        limit_d = cur_q[BIT_LIMIT];
                        ce_d = 1'b1;
                        oe_d = 1'b1;
                        state_d = S_RD_LO;
                    end
                end
            end
            S_FINAL: begin
                cnt_d = cnt_q + 2'h1;
                if (cnt_q + 2'h1 >= ACC_CYC) begin
                    cnt_d = 2'h0;
                    prev_d = cur_q;
                    cur_d = dq_in;
                    rdata_d = dq_in;
                    oe_d = 1'b0;
                    ce_d = 1'b0;
                    state_d = S_RD_HI;
                    op_d = OP_STATUS;
                    fail_d = 1'b0;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
        // the final reread decides pass on the data poll bit
        if (state_q == S_FINAL && state_d == S_RD_HI) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            state_d = S_IDLE;
            fail_d = (op_q == OP_PROGRAM) ?
                (dq_in[BIT_POLL] != wdata_q[BIT_POLL]) :
                !dq_in[BIT_POLL];
            op_d = op_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            op_q <= OP_READ;
            step_q <= 3'h0;
            cnt_q <= 2'h0;
            nrd_q <= 2'h0;
            addr_q <= '0;
            fa_q <= '0;
            wdata_q <= '0;
            dqo_q <= '0;
            cur_q <= '0;
            prev_q <= '0;
            rdata_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            tog1_q <= 1'b0;
            tog2_q <= 1'b0;
            timer_q <= 1'b0;
            limit_q <= 1'b0;
            failrst_q <= 1'b0;
            oe_q <= 1'b0;
            ce_q <= 1'b0;
            we_q <= 1'b0;
            dqoe_q <= 1'b0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            step_q <= step_d;
            cnt_q <= cnt_d;
            nrd_q <= nrd_d;
            addr_q <= addr_d;
            fa_q <= fa_d;
            wdata_q <= wdata_d;
            dqo_q <= dqo_d;
            cur_q <= cur_d;
            prev_q <= prev_d;
            rdata_q <= rdata_d;
            busy_q <= busy_d;
            done_q <= done_d;
            fail_q <= fail_d;
            tog1_q <= tog1_d;
            tog2_q <= tog2_d;
            timer_q <= timer_d;
            limit_q <= limit_d;
            failrst_q <= failrst_d;
            oe_q <= oe_d;
            ce_q <= ce_d;
            we_q <= we_d;
            dqoe_q <= dqoe_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign flash_addr = fa_q;
    assign dq_out = dqo_q;
    assign dq_oe = dqoe_q;
    assign ce_n = !ce_q;
    assign oe_n = !oe_q;
    assign we_n = !we_q;
endmodule // fws_ctrl

// file: tb/fws_ctrl_checker.sv
// assertion checker bound to the flash status-polling controller
`timescale 1ns/1ns
module fws_ctrl_checker
    import fws_pkg::*;
(
    // clock and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // flash pins
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic ready_busy_n
);
    logic [ADDR_W-1:0] wr_addr_q;
    logic chip_q;
    // last command write address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_addr_q <= '0;
            chip_q <= 1'b0;
        end else if (!we_n && !ce_n) begin
            wr_addr_q <= flash_addr;
            chip_q <= (dq_out == CMD_CHIP);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_one_wait;
        !pready ##1 pready;
    endsequence
    sequence s_read_end;
        !ce_n && !dq_oe ##1 oe_n;
    endsequence
    a_apb_one_wait: assert property (psel && penable && !$past(penable)
        |-> s_one_wait) else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_one_strobe: assert property (!(!we_n && !oe_n))
        else $error("write and read strobes together");
    a_write_setup: assert property (!we_n |-> dq_oe && !ce_n
        && $past(dq_oe) && !$past(ce_n)) else $error("write pulse unset");
    a_write_pulse: assert property ($fell(we_n) |=> we_n && ce_n && !dq_oe)
        else $error("write pulse not one cycle");
    a_read_pulse: assert property ($fell(oe_n) |-> s_read_end)
        else $error("read cycle malformed");
    a_poll_address: assert property (
        $fell(oe_n) && !ready_busy_n && !chip_q |-> flash_addr == wr_addr_q)
        else $error("status polled at wrong address");
endmodule // fws_ctrl_checker
bind fws_ctrl fws_ctrl_checker u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .ready_busy_n(ready_busy_n));

// file: tb/fws_flash_model.sv
// behavioural flash device answering status polls
`timescale 1ns/1ns
module fws_flash_model
    import fws_pkg::*;
(
    // bus
    input wire logic pclk,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] dq_out,
    output logic [DATA_W-1:0] dq_in,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic ready_busy_n,
    // scenario knobs
    input wire logic [15:0] busy_len,
    input wire logic stuck
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] pdata = '0;
    logic [DATA_W-1:0] last_q = '0;
    logic [DATA_W-1:0] rd_word;
    logic [3:0] pa = '0;
    logic busy = 1'b0, erase = 1'b0, arm = 1'b0, limit = 1'b0;
    logic tog1 = 1'b0, tog2 = 1'b0;
    int cnt = 0;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    assign rd_word = !busy ? mem[flash_addr[3:0]] : {8'h00,
        erase ? 1'b0 : ~pdata[7], tog1, limit, 1'b0, erase,
        erase & tog2, 2'b00};
    assign dq_in = (!ce_n && !oe_n) ? rd_word : ~last_q;
    assign ready_busy_n = ~busy;
    always @(posedge pclk) begin
        if (!ce_n && !we_n) begin
            if (busy) begin
                if (limit && dq_out == CMD_RESET) busy <= 1'b0;
            end else if (arm || dq_out == CMD_SECT || dq_out == CMD_CHIP) begin
                busy <= 1'b1;
                erase <= !arm;
                arm <= 1'b0;
                cnt <= 0;
                limit <= 1'b0;
                pa <= flash_addr[3:0];
                pdata <= dq_out;
            end else if (dq_out == CMD_PROG) begin
                arm <= 1'b1;
            end
        end
        if (!ce_n && !oe_n) begin
            last_q <= rd_word;
            tog1 <= tog1 ^ busy;
            tog2 <= tog2 ^ (busy & erase);
        end
        if (busy && we_n) begin
            cnt <= cnt + 1;
            if (cnt >= busy_len && stuck) limit <= 1'b1;
            if (cnt >= busy_len && !stuck) begin
                busy <= 1'b0;
                if (erase) foreach (mem[i]) mem[i] <= 16'hFFFF;
                else mem[pa] <= pdata;
            end
        end
    end
endmodule // fws_flash_model

// file: tb/tb.sv
// self-checking bench for the flash status-polling controller
`timescale 1ns/1ns
module tb
    import fws_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stuck = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, dq_oe, ce_n, oe_n, we_n, ready_busy_n;
    logic [ADDR_W-1:0] flash_addr;
    logic [DATA_W-1:0] dq_out, dq_in;
    logic [15:0] busy_len = 16'h0010;
    int seed = 90;
    int bad_count = 0;
    int comparisons = 0;
    always #50 pclk = ~pclk;
    fws_ctrl u_fws_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .ready_busy_n(ready_busy_n));
    fws_flash_model u_fws_flash_model (.pclk(pclk), .flash_addr(flash_addr),
        .dq_out(dq_out), .dq_in(dq_in), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .ready_busy_n(ready_busy_n), .busy_len(busy_len),
        .stuck(stuck));
    task automatic summarize();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic hang(input int n, input int lim);
        if (n >= lim) begin
            bad_count++;
            $display("wrong value at %0t: wait ran out", $time);
            summarize();
        end
    endtask
    function automatic logic [31:0] exp_done(input logic fail);
        return {29'h0, fail, 1'b1, 1'b0};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        hang(n, 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run_op(input logic [2:0] op, input logic [20:0] a,
        input logic [15:0] d, input logic fail, input logic [16:0] rd);
        logic [31:0] r, st;
        logic e, seen;
        int n;
        apb(1'b1, REG_ADDR, 32'(a), r, e);
        apb(1'b1, REG_WDATA, 32'(d), r, e);
        apb(1'b1, REG_CTRL, {28'h0, op, 1'b1}, r, e);
        seen = 1'b0;
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, st, e);
            if (st[ST_BUSY] === 1'b1 && st[ST_RDY_PIN] === 1'b0) seen = 1'b1;
            n++;
        end while (!(st[ST_DONE] === 1'b1 && st[ST_BUSY] === 1'b0) && n < 3000);
        hang(n, 3000);
        chk(st & 32'h7, exp_done(fail));
        chk(32'(st[ST_RDY_PIN]), 32'h1);
        if (op != OP_READ) chk(32'(seen), 32'h1);
        apb(1'b0, REG_RDATA, 32'h0, r, e);
        if (rd[16]) chk(r & 32'hFFFF, 32'(rd[15:0]));
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        logic [20:0] a;
        logic [15:0] d;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk(r, 32'h0);
        chk(32'(e), 32'h1);
        for (int i = 0; i < 5; i++) begin
            a = 21'($random(seed) & 15);
            d = (i == 0) ? 16'h0080 : (i == 1) ? 16'hFF7F : 16'($random(seed));
            busy_len <= 16'(8 + ($random(seed) & 31));
            run_op(OP_PROGRAM, a, d, 1'b0, {1'b1, d});
            run_op(OP_READ, a, 16'h0, 1'b0, {1'b1, d});
        end
        run_op(OP_SECT_ERASE, a, 16'h0, 1'b0, 17'h1FFFF);
        run_op(OP_READ, a, 16'h0, 1'b0, 17'h1FFFF);
        run_op(OP_PROGRAM, 21'h3, 16'h1234, 1'b0, 17'h11234);
        run_op(OP_CHIP_ERASE, 21'h3, 16'h0, 1'b0, 17'h0);
        run_op(OP_READ, 21'h3, 16'h0, 1'b0, 17'h1FFFF);
        stuck <= 1'b1;
        run_op(OP_PROGRAM, 21'h5, 16'h00AB, 1'b1, 17'h0);
        stuck <= 1'b0;
        run_op(OP_PROGRAM, 21'h5, 16'h00CD, 1'b0, 17'h100CD);
        summarize();
    end
endmodule // tb
